//--- design/dcc_channel.sv
// dma channel control: axi4-lite register slave plus slot mover
// assumes one ref_clk domain, synchronous active-high srst, 32-bit axi4-lite master
// one write and one read at a time; busy and slot status come live from the slot mover, overrun is a sticky flag held here
`timescale 1ns/1ps
`default_nettype none
module dcc_channel (
    input  wire logic               ref_clk,
    input  wire logic               srst,
    input  wire logic [15:0]        s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [15:0]        s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    output logic                    channel_enable_bit,
    output logic                    wrap_buffer_enable,
    output logic                    endpoint_direction,
    output logic [2:0]              endpoint_number_sel,
    input  wire logic               slot_start,
    input  wire logic [3:0]         slot_index,
    output var  dcc_pkg::dcc_xfer_t ubm_xfer,
    input  wire logic               ubm_ack,
    input  wire logic [7:0]         ubm_rdata,
    output var  dcc_pkg::dcc_xfer_t codec_xfer,
    input  wire logic               codec_ack,
    input  wire logic [7:0]         codec_rdata
);

    typedef struct packed {
        dcc_pkg::dcc_ctl_t      ctl;
        dcc_pkg::dcc_slot_cfg_t slot_cfg;
        logic                   overrun_flag;
        logic                   aw_held;
        logic [15:0]            aw_addr;
        logic                   w_held;
        logic [31:0]            w_data;
        logic [3:0]             w_strb;
        logic                   awready;
        logic                   wready;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   arready;
        logic                   rvalid;
        logic [1:0]             rresp;
        logic [31:0]            rdata;
    } dcc_regs_t;

    dcc_regs_t  s;
    dcc_regs_t  next_s;
    logic       mv_busy;
    logic       mv_overrun;
    logic [3:0] mv_slot;
    logic [7:0] status_byte;
    logic       wr_commit;
    logic       rd_take;

    // the mover latches direction per slot, so a control rewrite mid-slot only matters if it clears enable, which ends the slot at the next byte
    dcc_slot_mover u_mover (
        .ref_clk    (ref_clk),
        .srst       (srst),
        .ctl        (s.ctl),
        .slot_cfg   (s.slot_cfg),
        .slot_start (slot_start),
        .slot_index (slot_index),
        .buf_ack    (ubm_ack),
        .buf_rdata  (ubm_rdata),
        .cp_ack     (codec_ack),
        .cp_rdata   (codec_rdata),
        .buf_port   (ubm_xfer),
        .cp_port    (codec_xfer),
        .busy       (mv_busy),
        .overrun    (mv_overrun),
        .cur_slot   (mv_slot)
    );

    always_comb begin
        wr_commit = s.aw_held && s.w_held && !s.bvalid;
        rd_take   = s_axi_arvalid && s.arready;

        // status is assembled live so busy and slot follow the mover
        status_byte = 8'h00;
        status_byte[dcc_pkg::STAT_OVERRUN] = s.overrun_flag;
        status_byte[dcc_pkg::STAT_BUSY]    = mv_busy;
        status_byte[dcc_pkg::STAT_SLOT_LSB +: 4] = mv_slot;

        next_s = s;

        // write commit once both address and data are held
        if (wr_commit) begin
            next_s.aw_held = 1'b0;
            next_s.w_held  = 1'b0;
            next_s.bvalid  = 1'b1;
            next_s.bresp   = dcc_pkg::RESP_OKAY;
            unique case (s.aw_addr)
                dcc_pkg::ADDR_CTRL: begin
                    if (s.w_strb[0]) begin
                        // reserved bits masked so they always read back zero
                        next_s.ctl = s.w_data[7:0] & dcc_pkg::CTRL_WMASK;
                    end
                end
                dcc_pkg::ADDR_SLOT: begin
                    // lane 1 carries bytes per slot and the top six select bits
                    if (s.w_strb[0]) begin
                        next_s.slot_cfg[7:0] = s.w_data[7:0];
                    end
                    if (s.w_strb[1]) begin
                        next_s.slot_cfg[15:8] = s.w_data[15:8];
                    end
                end
                dcc_pkg::ADDR_STATUS: begin
                    // writing one clears overrun; busy and slot are read only
                    if (s.w_strb[0] && s.w_data[dcc_pkg::STAT_OVERRUN]) begin
                        next_s.overrun_flag = 1'b0;
                    end
                end
                default: begin
                    next_s.bresp = dcc_pkg::RESP_SLVERR;
                end
            endcase
        end
        // a new overrun in the clearing cycle still sets the flag
        if (mv_overrun) begin
            next_s.overrun_flag = 1'b1;
        end

        // address and data may be taken in either order, each held until commit
        if (s_axi_awvalid && s.awready) begin
            next_s.aw_held = 1'b1;
            next_s.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s.wready) begin
            next_s.w_held = 1'b1;
            next_s.w_data = s_axi_wdata;
            next_s.w_strb = s_axi_wstrb;
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end

        // reads answer in the cycle after the address is taken, no wait states
        if (rd_take) begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = dcc_pkg::RESP_OKAY;
            next_s.rdata  = 32'h00000000;
            unique case (s_axi_araddr)
                dcc_pkg::ADDR_CTRL: begin
                    next_s.rdata[7:0] = s.ctl;
                end
                dcc_pkg::ADDR_SLOT: begin
                    next_s.rdata[15:0] = s.slot_cfg;
                end
                dcc_pkg::ADDR_STATUS: begin
                    next_s.rdata[7:0] = status_byte;
                end
                default: begin
                    next_s.rresp = dcc_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end

        // one write and one read in flight at most
        // a pending response blocks both write channels until it is taken
        next_s.awready = !next_s.aw_held && !next_s.bvalid;
        next_s.wready  = !next_s.w_held && !next_s.bvalid;
        next_s.arready = !next_s.rvalid;
    end

    // reset values come from the package so reads right after reset match
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s          <= '0;
            s.ctl      <= dcc_pkg::CTRL_RST;
            s.slot_cfg <= dcc_pkg::SLOT_RST;
        end else begin
            s <= next_s;
        end
    end

    assign s_axi_awready       = s.awready;
    assign s_axi_wready        = s.wready;
    assign s_axi_bvalid        = s.bvalid;
    assign s_axi_bresp         = s.bresp;
    assign s_axi_arready       = s.arready;
    assign s_axi_rvalid        = s.rvalid;
    assign s_axi_rresp         = s.rresp;
    assign s_axi_rdata         = s.rdata;
    // control pins come straight from the register flip-flops
    assign channel_enable_bit  = s.ctl.enable;
    assign wrap_buffer_enable  = s.ctl.wrap;
    assign endpoint_direction  = s.ctl.dir_in;
    assign endpoint_number_sel = s.ctl.endpoint;

endmodule : dcc_channel
`default_nettype wire

//--- design/dcc_pkg.sv
// shared types and constants for the dma channel control block
// assumes a single ref_clk domain and a 16-bit register byte address space
package dcc_pkg;

    // register byte addresses
    localparam logic [15:0] ADDR_CTRL   = 16'hffe8;
    localparam logic [15:0] ADDR_SLOT   = 16'hffec;
    localparam logic [15:0] ADDR_STATUS = 16'hfff0;

    // values after reset
    localparam logic [7:0]  CTRL_RST = 8'h00;
    localparam logic [15:0] SLOT_RST = 16'h0000;

    // writable control bits: enable, wrap, direction, endpoint; bits 5:4 stay zero
    localparam logic [7:0]  CTRL_WMASK = 8'hcf;

    localparam int          NUM_SLOTS  = 14;
    localparam logic [3:0]  SLOT_LIMIT = 4'he;

    // status field positions
    localparam int          STAT_OVERRUN = 0;
    localparam int          STAT_BUSY    = 1;
    localparam int          STAT_SLOT_LSB = 4;

    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic       enable;
        logic       wrap;
        logic [1:0] rsvd;
        logic       dir_in;
        logic [2:0] endpoint;
    } dcc_ctl_t;

    typedef struct packed {
        logic [1:0]  bytes_per_slot;
        logic [13:0] slot_select_bits;
    } dcc_slot_cfg_t;

    // one byte request toward the buffer manager or the codec port
    typedef struct packed {
        logic       req;
        logic       write;
        logic [7:0] data;
    } dcc_xfer_t;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_SRC,
        SEQ_DST
    } dcc_seq_state_t;

endpackage : dcc_pkg

//--- design/dcc_slot_mover.sv
// per-slot byte mover between endpoint buffer and codec port
// assumes both far ends answer a held req with a one-cycle ack
`timescale 1ns/1ps
`default_nettype none
module dcc_slot_mover (
    input  wire logic                   ref_clk,
    input  wire logic                   srst,
    input  wire dcc_pkg::dcc_ctl_t      ctl,
    input  wire dcc_pkg::dcc_slot_cfg_t slot_cfg,
    input  wire logic                   slot_start,
    input  wire logic [3:0]             slot_index,
    input  wire logic                   buf_ack,
    input  wire logic [7:0]             buf_rdata,
    input  wire logic                   cp_ack,
    input  wire logic [7:0]             cp_rdata,
    output var  dcc_pkg::dcc_xfer_t     buf_port,
    output var  dcc_pkg::dcc_xfer_t     cp_port,
    output logic                        busy,
    output logic                        overrun,
    output logic [3:0]                  cur_slot
);

    typedef struct packed {
        dcc_pkg::dcc_seq_state_t state;
        logic                    dir_in;
        logic [1:0]              left;
        logic [3:0]              slot;
        logic                    overrun;
        dcc_pkg::dcc_xfer_t      bufx;
        dcc_pkg::dcc_xfer_t      cpx;
    } dcc_mover_t;

    dcc_mover_t s;
    dcc_mover_t next_s;
    logic       hit;
    logic       src_ack;
    logic       dst_ack;
    logic [7:0] src_data;

    always_comb begin
        // a slot is ours only while enabled and its select bit is set
        hit      = slot_start && ctl.enable && (slot_index < dcc_pkg::SLOT_LIMIT)
                   && slot_cfg.slot_select_bits[slot_index];
        src_ack  = s.dir_in ? cp_ack : buf_ack;
        dst_ack  = s.dir_in ? buf_ack : cp_ack;
        src_data = s.dir_in ? cp_rdata : buf_rdata;
        next_s   = s;
        next_s.overrun = 1'b0;
        unique case (s.state)
            dcc_pkg::SEQ_IDLE: begin
                if (hit) begin
                    next_s.state  = dcc_pkg::SEQ_SRC;
                    next_s.dir_in = ctl.dir_in;
                    next_s.left   = slot_cfg.bytes_per_slot;
                    next_s.slot   = slot_index;
                    next_s.cpx    = '{req: ctl.dir_in, write: 1'b0, data: 8'h00};
                    next_s.bufx   = '{req: !ctl.dir_in, write: 1'b0, data: 8'h00};
                end
            end
            dcc_pkg::SEQ_SRC: begin
                if (src_ack) begin
                    next_s.state = dcc_pkg::SEQ_DST;
                    // in: codec to buffer; out: buffer to codec
                    next_s.cpx   = '{req: !s.dir_in, write: 1'b1, data: src_data};
                    next_s.bufx  = '{req: s.dir_in, write: 1'b1, data: src_data};
                end
            end
            dcc_pkg::SEQ_DST: begin
                if (dst_ack) begin
                    next_s.cpx.req  = 1'b0;
                    next_s.bufx.req = 1'b0;
                    // disabling ends the slot at a byte boundary, never mid-handshake
                    if (s.left == 2'h0 || !ctl.enable) begin
                        next_s.state = dcc_pkg::SEQ_IDLE;
                    end else begin
                        next_s.state = dcc_pkg::SEQ_SRC;
                        next_s.left  = s.left - 2'h1;
                        next_s.cpx   = '{req: s.dir_in, write: 1'b0, data: 8'h00};
                        next_s.bufx  = '{req: !s.dir_in, write: 1'b0, data: 8'h00};
                    end
                end
            end
            default: begin
                next_s = '0;
            end
        endcase
        // a selected slot arriving while still busy is dropped and reported
        if (s.state != dcc_pkg::SEQ_IDLE && slot_start && ctl.enable
            && (slot_index < dcc_pkg::SLOT_LIMIT) && slot_cfg.slot_select_bits[slot_index]) begin
            next_s.overrun = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign buf_port = s.bufx;
    assign cp_port  = s.cpx;
    assign busy     = (s.state != dcc_pkg::SEQ_IDLE);
    assign overrun  = s.overrun;
    assign cur_slot = s.slot;

endmodule : dcc_slot_mover
`default_nettype wire

//--- sim/dcc_channel_props.sv
// concurrent checks on the dma channel control ports
// assumes one ref_clk domain and synchronous active-high srst
`timescale 1ns/1ps
`default_nettype none
module dcc_channel_props (
    input wire logic               ref_clk,
    input wire logic               srst,
    input wire logic [15:0]        s_axi_araddr,
    input wire logic               s_axi_arvalid,
    input wire logic               s_axi_arready,
    input wire logic               s_axi_rvalid,
    input wire logic [31:0]        s_axi_rdata,
    input wire logic               s_axi_bvalid,
    input wire logic               s_axi_bready,
    input wire logic [1:0]         s_axi_bresp,
    input wire logic               channel_enable_bit,
    input wire logic               wrap_buffer_enable,
    input wire logic               endpoint_direction,
    input wire logic [2:0]         endpoint_number_sel,
    input wire logic               slot_start,
    input wire dcc_pkg::dcc_xfer_t ubm_xfer,
    input wire logic               ubm_ack,
    input wire logic [7:0]         ubm_rdata,
    input wire dcc_pkg::dcc_xfer_t codec_xfer,
    input wire logic               codec_ack,
    input wire logic [7:0]         codec_rdata
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    // readback must match the exported pins, reserved bits zero
    AST_CTRL_READBACK: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr == dcc_pkg::ADDR_CTRL |=>
        s_axi_rvalid && s_axi_rdata == {24'h0, $past(channel_enable_bit),
        $past(wrap_buffer_enable), 2'b00, $past(endpoint_direction), $past(endpoint_number_sel)})
        else $error("control readback differs from pins");
    AST_B_HOLD: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    AST_B_ONCE: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated after handshake");
    AST_SRC_ENABLED: assert property (
        $rose(ubm_xfer.req && !ubm_xfer.write) || $rose(codec_xfer.req && !codec_xfer.write)
        |-> $past(channel_enable_bit))
        else $error("source read started while disabled");
    AST_OUT_DIR: assert property (
        slot_start ##1 $rose(ubm_xfer.req && !ubm_xfer.write) |-> !$past(endpoint_direction))
        else $error("buffer read started in in direction");
    AST_IN_DIR: assert property (
        slot_start ##1 $rose(codec_xfer.req && !codec_xfer.write) |-> $past(endpoint_direction))
        else $error("codec read started in out direction");
    AST_BUF_TO_CODEC: assert property (
        ubm_ack && ubm_xfer.req && !ubm_xfer.write |=>
        codec_xfer.req && codec_xfer.write && codec_xfer.data == $past(ubm_rdata))
        else $error("buffer byte not passed to codec");
    AST_CODEC_TO_BUF: assert property (
        codec_ack && codec_xfer.req && !codec_xfer.write |=>
        ubm_xfer.req && ubm_xfer.write && ubm_xfer.data == $past(codec_rdata))
        else $error("codec byte not passed to buffer");
    AST_REQ_HOLD: assert property (
        codec_xfer.req && !codec_ack |=> $stable(codec_xfer))
        else $error("codec request changed before ack");
endmodule : dcc_channel_props
bind dcc_channel dcc_channel_props u_dcc_channel_props (.ref_clk(ref_clk), .srst(srst),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .channel_enable_bit(channel_enable_bit), .wrap_buffer_enable(wrap_buffer_enable),
    .endpoint_direction(endpoint_direction), .endpoint_number_sel(endpoint_number_sel),
    .slot_start(slot_start), .ubm_xfer(ubm_xfer), .ubm_ack(ubm_ack), .ubm_rdata(ubm_rdata),
    .codec_xfer(codec_xfer), .codec_ack(codec_ack), .codec_rdata(codec_rdata));
`default_nettype wire

//--- sim/dcc_far_model.sv
// byte responder standing for the buffer manager or the codec port
// assumes a held req answered by one ack pulse after LAT idle cycles
`timescale 1ns/1ps
`default_nettype none
module dcc_far_model #(
    parameter int         LAT  = 0,
    parameter logic [7:0] BASE = 8'h00
) (
    input wire logic               ref_clk,
    input wire logic               srst,
    input wire dcc_pkg::dcc_xfer_t xfer,
    output logic                   ack,
    output logic [7:0]             rdata,
    output logic [7:0]             wr_data,
    output logic [7:0]             wr_cnt,
    output logic [7:0]             rd_cnt
);
    logic [3:0] wait_cnt;
    always_ff @(posedge ref_clk) begin
        ack <= 1'b0;
        // read data only valid with ack, so it churns otherwise
        rdata <= ~rdata;
        if (srst) begin
            {wait_cnt, rdata, wr_data, wr_cnt, rd_cnt} <= '0;
        end else if (xfer.req && !ack) begin
            wait_cnt <= wait_cnt + 4'h1;
            if (wait_cnt == 4'(LAT)) begin
                ack <= 1'b1;
                wait_cnt <= 4'h0;
                if (xfer.write) begin
                    wr_data <= xfer.data;
                    wr_cnt <= wr_cnt + 8'h01;
                end else begin
                    rdata <= BASE + rd_cnt;
                    rd_cnt <= rd_cnt + 8'h01;
                end
            end
        end
    end
endmodule : dcc_far_model
`default_nettype wire

//--- sim/tb_dcc_channel.sv
// register and slot transfer tests for the dma channel control block
// assumes the far ends are dcc_far_model instances, fast buffer, slow codec
`timescale 1ns/1ps
`default_nettype none
module tb_dcc_channel;
    logic ref_clk, srst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, channel_enable_bit, wrap_buffer_enable, endpoint_direction;
    logic slot_start, ubm_ack, codec_ack;
    logic [15:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb, slot_index;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [2:0] endpoint_number_sel;
    logic [7:0] ubm_rdata, codec_rdata, u_wd, u_wc, u_rc, c_wd, c_wc, c_rc;
    logic [7:0] eu_r = 8'h00, eu_w = 8'h00, ec_r = 8'h00, ec_w = 8'h00;
    dcc_pkg::dcc_xfer_t ubm_xfer, codec_xfer;
    int fail_count = 0, num_checks = 0;
    dcc_channel u_dcc_channel (.ref_clk(ref_clk), .srst(srst), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .channel_enable_bit(channel_enable_bit),
        .wrap_buffer_enable(wrap_buffer_enable), .endpoint_direction(endpoint_direction),
        .endpoint_number_sel(endpoint_number_sel), .slot_start(slot_start),
        .slot_index(slot_index), .ubm_xfer(ubm_xfer), .ubm_ack(ubm_ack), .ubm_rdata(ubm_rdata),
        .codec_xfer(codec_xfer), .codec_ack(codec_ack), .codec_rdata(codec_rdata));
    dcc_far_model #(.LAT(0), .BASE(8'h40)) u_dcc_far_model (.ref_clk(ref_clk),
        .srst(srst), .xfer(ubm_xfer), .ack(ubm_ack), .rdata(ubm_rdata),
        .wr_data(u_wd), .wr_cnt(u_wc), .rd_cnt(u_rc));
    dcc_far_model #(.LAT(2), .BASE(8'hc0)) u_dcc_far_model_2 (.ref_clk(ref_clk),
        .srst(srst), .xfer(codec_xfer), .ack(codec_ack), .rdata(codec_rdata),
        .wr_data(c_wd), .wr_cnt(c_wc), .rd_cnt(c_rc));
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, v, 4'hf};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a);
        @(posedge ref_clk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
        do begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        {d, r} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic pulse(input logic [3:0] i);
        @(posedge ref_clk);
        {slot_start, slot_index} <= {1'b1, i};
        @(posedge ref_clk);
        slot_start <= 1'b0;
    endtask : pulse
    initial begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        wrap_up();
    end
    initial begin
        srst = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, slot_start, slot_index} = '0;
        repeat (8) @(posedge ref_clk);
        srst <= 1'b0;
        rd(dcc_pkg::ADDR_CTRL);
        chk("ctrl reset", 32'h0, d);
        rd(dcc_pkg::ADDR_SLOT);
        chk("slot reset", 32'h0, d);
        wr(dcc_pkg::ADDR_CTRL, 32'hff);
        rd(dcc_pkg::ADDR_CTRL);
        chk("ctrl reserved", 32'hcf, d);
        for (int e = 1; e < 8; e++) begin
            wr(dcc_pkg::ADDR_CTRL, {24'h0, 1'b0, e[0], 2'b11, e[1], e[2:0]});
            chk("ctrl pins", {1'b0, e[0], e[1], e[2:0]}, {channel_enable_bit,
                wrap_buffer_enable, endpoint_direction, endpoint_number_sel});
        end
        wr(16'hffe9, 32'h1);
        chk("unmapped bresp", dcc_pkg::RESP_SLVERR, r);
        rd(16'hffe4);
        chk("unmapped rresp", dcc_pkg::RESP_SLVERR, r);
        chk("unmapped rdata", 32'h0, d);
        // configure while disabled, then a slot pulse must do nothing
        wr(dcc_pkg::ADDR_CTRL, 32'h09);
        wr(dcc_pkg::ADDR_SLOT, 32'h2004);
        pulse(4'h2);
        repeat (20) @(posedge ref_clk);
        chk("disabled", 32'h0, {u_rc, u_wc, c_rc, c_wc});
        for (int b = 0; b < 4; b++) begin
            // disable before reconfiguring, endpoint kept non-zero
            wr(dcc_pkg::ADDR_CTRL, 32'h01);
            wr(dcc_pkg::ADDR_SLOT, {16'h0, b[1:0], 14'h2004});
            wr(dcc_pkg::ADDR_CTRL, {24'h0, 4'h8, b[0], 3'(b + 1)});
            pulse(b[0] ? 4'hd : 4'h2);
            if (b[0]) {ec_r, eu_w} = {ec_r + 8'(b + 1), eu_w + 8'(b + 1)};
            else {eu_r, ec_w} = {eu_r + 8'(b + 1), ec_w + 8'(b + 1)};
            for (int n = 0; n < 200 && {u_rc, u_wc, c_rc, c_wc} !== {eu_r, eu_w, ec_r, ec_w}; n++)
                @(posedge ref_clk);
            repeat (10) @(posedge ref_clk);
            chk("byte counts", {eu_r, eu_w, ec_r, ec_w}, {u_rc, u_wc, c_rc, c_wc});
            chk("byte data", b[0] ? 8'hbf + ec_r : 8'h3f + eu_r, b[0] ? u_wd : c_wd);
        end
        pulse(4'hc);
        pulse(4'he);
        repeat (20) @(posedge ref_clk);
        chk("unselected", {eu_r, eu_w, ec_r, ec_w}, {u_rc, u_wc, c_rc, c_wc});
        // a second selected pulse while busy is dropped and flagged in status
        pulse(4'hd);
        pulse(4'hd);
        {ec_r, eu_w} = {ec_r + 8'h04, eu_w + 8'h04};
        repeat (60) @(posedge ref_clk);
        chk("overrun counts", {eu_r, eu_w, ec_r, ec_w}, {u_rc, u_wc, c_rc, c_wc});
        rd(dcc_pkg::ADDR_STATUS);
        chk("status overrun", 32'hd1, d);
        wr(dcc_pkg::ADDR_STATUS, 32'h1);
        rd(dcc_pkg::ADDR_STATUS);
        chk("status cleared", 32'hd0, d);
        wrap_up();
    end
endmodule : tb_dcc_channel
`default_nettype wire
